/* hdl/icr_isa_clock_reset_gen.sv */
// Expansion bus clock and reset generator with its divisor register.
// Function
// (RQ1) Expansion reset is inverse of host reset.
// (RQ2) Expansion clock divides host bus clock.
// (RQ3) Divisor field is bits 2:0 at 50h.
// (RQ4) Code 010 divides by three.
// (RQ5) Code 011 divides by four.
// (RQ6) Software writes only the two valid codes.
// (RQ7) Host bus clock drives internal logic.
// (RQ8) Drive line high one clock before release.
// (RQ9) New driver waits one clock after release.
// (RQ10) Divisor reached through configuration space.
// (RQ11) New divisor applied at period boundary.
`timescale 1ns/1ps
`include "icr_params.svh"
module icr_isa_clock_reset_gen
   import icr_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       host_bus_reset_n_i,
   input  wire logic       cfg_wr_i,
   input  wire logic       cfg_rd_i,
   input  wire logic [7:0] cfg_addr_i,
   input  wire logic [7:0] cfg_wdata_i,
   output logic      [7:0] cfg_rdata_o,
   output logic            expansion_clock_o,
   output logic            expansion_reset_out_o,
   input  wire logic       line_req_i,
   input  wire logic       line_low_i,
   input  wire logic       line_i,
   output logic            line_o,
   output logic            line_oe_o,
   output logic            line_busy_o
);
   icr_div_if div_bus ();
   icr_byte_t        cfg_q;
   icr_byte_t        rdata_q;
   logic             rst_out_q;
   icr_line_state_t  st_q;
   icr_line_state_t  st_d;
   logic       [1:0] gap_q;
   // Configuration space decode for the divisor register (see RQ3 see RQ10).
   wire        hit_div = (cfg_addr_i == `ICR_CFG_DIV_OFFSET);
   wire        wr_div  = cfg_wr_i && hit_div;
   wire icr_div_code_t code = cfg_q[`ICR_DIV_FIELD_MSB:`ICR_DIV_FIELD_LSB];
   // Invalid codes are left alone so the clock keeps its last good rate (see RQ6).
   wire        code_ok = (code == `ICR_DIV_CODE_BY3) || (code == `ICR_DIV_CODE_BY4);
   assign div_bus.div_valid = code_ok;
   assign div_bus.div_last  = (code == `ICR_DIV_CODE_BY3) ? `ICR_DIV_COUNT_BY3
                                                          : `ICR_DIV_COUNT_BY4;
   // All logic runs on the host bus clock (see RQ7).
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         cfg_q     <= `ICR_CFG_DIV_RESET;
         rdata_q   <= 8'h00;
         rst_out_q <= 1'b1;
      end else begin
         if (wr_div) begin
            cfg_q <= cfg_wdata_i;
         end
         if (cfg_rd_i) begin
            rdata_q <= hit_div ? cfg_q : 8'h00;
         end
         rst_out_q <= ~host_bus_reset_n_i; // see RQ1
      end
   end
   icr_clk_div u_div (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .cfg       (div_bus),
      .clk_o     (expansion_clock_o)
   );
   // Shared line: after driving low, drive high one clock, then release (see RQ8).
   // A new claim waits a clock after the line floats (see RQ9).
   always_comb begin
      st_d = st_q;
      case (st_q)
         ICR_LN_IDLE: begin
            if (line_req_i && gap_q == 2'h0 && line_i) begin
               st_d = line_low_i ? ICR_LN_LOW : ICR_LN_HIGH;
            end
         end
         ICR_LN_LOW: begin
            if (!line_low_i || !line_req_i) begin
               st_d = ICR_LN_HIGH; // see RQ8
            end
         end
         ICR_LN_HIGH: begin
            if (line_req_i && line_low_i) begin
               st_d = ICR_LN_LOW;
            end else if (!line_req_i) begin
               st_d = ICR_LN_RELEASE;
            end
         end
         ICR_LN_RELEASE: st_d = ICR_LN_IDLE;
         default: st_d = ICR_LN_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         st_q  <= ICR_LN_IDLE;
         gap_q <= 2'h0;
      end else begin
         st_q  <= st_d;
         gap_q <= (st_q == ICR_LN_RELEASE) ? `ICR_HANDOVER_CYCLES
                : (gap_q != 2'h0) ? gap_q - 2'h1 : 2'h0; // see RQ9
      end
   end
   assign line_o                = (st_q == ICR_LN_HIGH);
   assign line_oe_o             = (st_q == ICR_LN_LOW) || (st_q == ICR_LN_HIGH);
   assign line_busy_o           = (st_q != ICR_LN_IDLE) || (gap_q != 2'h0);
   assign cfg_rdata_o           = rdata_q;
   assign expansion_reset_out_o = rst_out_q;
endmodule

/* hdl/icr_params.svh */
// Constants for the expansion clock and reset generator.
`ifndef ICR_PARAMS_SVH
`define ICR_PARAMS_SVH
`define ICR_CFG_DIV_OFFSET  8'h50
`define ICR_DIV_FIELD_MSB   2
`define ICR_DIV_FIELD_LSB   0
`define ICR_CFG_DIV_RESET   8'h03
`define ICR_DIV_CODE_BY3    3'h2
`define ICR_DIV_CODE_BY4    3'h3
`define ICR_DIV_COUNT_BY3   2'h2
`define ICR_DIV_COUNT_BY4   2'h3
`define ICR_HANDOVER_CYCLES 2'h1
`endif

/* hdl/icr_pkg.sv */
// Types for the expansion clock and reset generator.
package icr_pkg;
   typedef logic [7:0] icr_byte_t;
   typedef logic [2:0] icr_div_code_t;
   typedef enum logic [3:0] {
      ICR_LN_IDLE    = 4'h1,
      ICR_LN_LOW     = 4'h2,
      ICR_LN_HIGH    = 4'h4,
      ICR_LN_RELEASE = 4'h8
   } icr_line_state_t;
endpackage

/* hdl/icr_div_if.sv */
// Interface carrying the divisor setting to the clock divider.
`timescale 1ns/1ps
interface icr_div_if;
   logic [1:0] div_last;
   logic       div_valid;
   modport src (output div_last, output div_valid);
   modport dst (input div_last, input div_valid);
endinterface

/* hdl/icr_clk_div.sv */
// Divider producing the expansion clock from the host bus clock.
`timescale 1ns/1ps
`include "icr_params.svh"
module icr_clk_div
   import icr_pkg::*;
(
   input  wire logic ref_clk_i,
   input  wire logic rst_b_i,
   icr_div_if.dst    cfg,
   output logic      clk_o
);
   logic [1:0] cnt_q;
   logic [1:0] last_q;
   logic       clk_q;
   wire        wrap = (cnt_q >= last_q);
   // The low phase is always two cycles, so divide by three is high for one cycle.
   wire  [1:0] half = 2'h1;
   // Divisor changes only at a period boundary, so no short pulse appears (see RQ11).
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         cnt_q  <= 2'h0;
         last_q <= `ICR_DIV_COUNT_BY4;
         clk_q  <= 1'b0;
      end else begin
         cnt_q <= wrap ? 2'h0 : cnt_q + 2'h1;
         if (wrap && cfg.div_valid) begin
            last_q <= cfg.div_last; // see RQ4 see RQ5
         end
         clk_q <= wrap ? 1'b0 : (cnt_q == half) ? 1'b1 : clk_q; // see RQ2
      end
   end
   assign clk_o = clk_q;
endmodule

/* tb/icr_sva.sv */
// Port assertions for the expansion clock and reset generator.
`timescale 1ns/1ps
module icr_sva (
   input wire logic ref_clk_i, rst_b_i, host_bus_reset_n_i, cfg_wr_i, cfg_rd_i, line_low_i,
   input wire logic [7:0] cfg_addr_i, cfg_wdata_i, cfg_rdata_o,
   input wire logic expansion_clock_o, expansion_reset_out_o, line_o, line_oe_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_lo; !expansion_clock_o [*2] ##1 expansion_clock_o; endsequence
   sequence s_wr; cfg_wr_i && cfg_addr_i == 8'h50; endsequence
   sequence s_rd; cfg_rd_i && cfg_addr_i == 8'h50; endsequence
   // The output register still shows its reset level on the first edge after release.
   property p_rs; $past(rst_b_i) |-> expansion_reset_out_o == !$past(host_bus_reset_n_i);
   endproperty
   property p_wr; s_wr ##2 s_rd |=> cfg_rdata_o == $past(cfg_wdata_i, 3); endproperty
   property p_ur; cfg_rd_i && cfg_addr_i != 8'h50 |=> cfg_rdata_o == 8'h00; endproperty
   property p_hi; $rose(expansion_clock_o) |=> ##[0:1] !expansion_clock_o; endproperty
   property p_lo; $fell(expansion_clock_o) |-> s_lo; endproperty
   property p_rh; $fell(line_oe_o) |-> $past(line_o); endproperty
   property p_gp; $fell(line_oe_o) |=> !line_oe_o; endproperty
   property p_lh; line_oe_o && !line_o && !line_low_i |=> line_oe_o && line_o; endproperty
   a_rs: assert property (p_rs) else $error("reset out");
   a_wr: assert property (p_wr) else $error("read back");
   a_ur: assert property (p_ur) else $error("unmapped read");
   a_hi: assert property (p_hi) else $error("high phase");
   a_lo: assert property (p_lo) else $error("low phase");
   a_rh: assert property (p_rh) else $error("release");
   a_gp: assert property (p_gp) else $error("gap");
   a_lh: assert property (p_lh) else $error("low to high");
endmodule
bind icr_isa_clock_reset_gen icr_sva u_sva (.*);

/* tb/icr_isa_dev.sv */
// Expansion bus device that times its clock and pulls the shared line up.
`timescale 1ns/1ps
module icr_isa_dev (
   input  wire logic       ref_clk_i,
   input  wire logic       expansion_clock_o,
   input  wire logic       line_o,
   input  wire logic       line_oe_o,
   output logic            line_i,
   output logic      [7:0] period_o
);
   logic [7:0] cnt_q = 8'h00;
   // Nobody driving leaves the line at the pull-up level.
   assign line_i = line_oe_o ? line_o : 1'b1;
   always_ff @(posedge ref_clk_i) begin
      cnt_q <= $rose(expansion_clock_o) ? 8'h01 : cnt_q + 8'h01;
      if ($rose(expansion_clock_o)) period_o <= cnt_q;
   end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the expansion clock and reset generator.
`timescale 1ns/1ps
module testbench;
   import icr_pkg::*;
   logic ref_clk_i = 1'b0, rst_b_i = 1'b0, host_bus_reset_n_i = 1'b1, cfg_wr_i = 1'b0;
   logic cfg_rd_i = 1'b0, line_req_i = 1'b0, line_low_i = 1'b0, line_i, line_o, line_oe_o;
   logic line_busy_o, expansion_clock_o, expansion_reset_out_o;
   icr_byte_t cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00, cfg_rdata_o, period_o, code;
   int mismatches = 0, checks = 0, cyc = 0;
   icr_isa_clock_reset_gen dut (.*);
   icr_isa_dev isa (.*);
   initial forever #20 ref_clk_i = ~ref_clk_i;
   function automatic icr_byte_t exp_per(icr_byte_t c); return c[0] ? 8'h04 : 8'h03; endfunction
   task automatic wrap_up();
      if (mismatches == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(icr_byte_t g, icr_byte_t e);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic waitc(int n); repeat (n) @(posedge ref_clk_i); #1; endtask
   task automatic cfg(logic w, icr_byte_t a, icr_byte_t d);
      @(posedge ref_clk_i);
      cfg_wr_i <= w;
      cfg_rd_i <= !w;
      cfg_addr_i <= a;
      cfg_wdata_i <= d;
      @(posedge ref_clk_i);
      cfg_wr_i <= 1'b0;
      cfg_rd_i <= 1'b0;
      #1;
   endtask
   task automatic drv(logic r, logic l, logic h, icr_byte_t e);
      @(posedge ref_clk_i);
      line_req_i <= r;
      line_low_i <= l;
      host_bus_reset_n_i <= h;
      waitc(3);
      chk({5'h00, expansion_reset_out_o, line_oe_o, line_i}, e);
   endtask
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(90));
      repeat (4) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      cfg(1'b0, 8'h50, 8'h00);
      chk(cfg_rdata_o, 8'h03);
      waitc(12);
      chk(period_o, 8'h04);
      for (int i = 0; i < 6; i++) begin
         code = {5'($urandom), (i[0] ? 3'h2 : 3'h3)};
         cfg(1'b1, 8'h50, code);
         cfg(1'b0, 8'h50, 8'h00);
         chk(cfg_rdata_o, code);
         waitc(12);
         chk(period_o, exp_per(code));
         cfg(1'b0, {i[1], 7'($urandom_range(32'h4F))}, 8'h00);
         chk(cfg_rdata_o, 8'h00);
      end
      drv(1'b1, 1'b1, 1'b0, 8'h06);
      drv(1'b1, 1'b0, 1'b1, 8'h03);
      drv(1'b0, 1'b0, 1'b1, 8'h01);
      wrap_up();
   end
endmodule
